//--- design/di_status_pkg.sv
// constants for the discrete input status block
package di_status_pkg;
	// parameter indexes seen by the fieldbus host
	localparam logic [7:0] IDX_STATIC_REV  = 8'h01;
	localparam logic [7:0] IDX_TAG_TEXT    = 8'h02;
	localparam logic [7:0] IDX_GROUPING    = 8'h03;
	localparam logic [7:0] IDX_PLANT_KEY   = 8'h04;
	localparam logic [7:0] IDX_MODE        = 8'h05;
	localparam logic [7:0] IDX_BLOCK_ERR   = 8'h06;
	localparam logic [7:0] IDX_PROC_VALUE  = 8'h07;
	localparam logic [7:0] IDX_OUTPUT      = 8'h08;
	localparam logic [7:0] IDX_SIMULATE    = 8'h09;
	localparam logic [7:0] IDX_IO_OPTIONS  = 8'h0d;
	localparam logic [7:0] IDX_CHANNEL     = 8'h0f;
	localparam logic [7:0] IDX_FILTER_TIME = 8'h10;
	localparam logic [7:0] IDX_FIELD_VALUE = 8'h11;
	localparam logic [7:0] IDX_ALARM_LIMIT = 8'h17;

	// sub-indexes
	localparam logic [7:0] SUB_MODE_TARGET = 8'h01;
	localparam logic [7:0] SUB_MODE_ACTUAL = 8'h02;
	localparam logic [7:0] SUB_SIM_STATUS  = 8'h01;
	localparam logic [7:0] SUB_SIM_VALUE   = 8'h02;
	localparam logic [7:0] SUB_XD_STATUS   = 8'h03;
	localparam logic [7:0] SUB_XD_VALUE    = 8'h04;
	localparam logic [7:0] SUB_SIM_ENABLE  = 8'h05;
	localparam logic [7:0] SUB_VALUE       = 8'h00;
	localparam logic [7:0] SUB_STATUS      = 8'h01;

	// mode bit strings
	localparam logic [7:0] MODE_OOS  = 8'h80;
	localparam logic [7:0] MODE_MAN  = 8'h10;
	localparam logic [7:0] MODE_AUTO = 8'h08;

	// block error bit positions
	localparam int BERR_CONFIG   = 1;
	localparam int BERR_SIMULATE = 3;
	localparam int BERR_BAD_PV   = 7;
	localparam int BERR_POWER_UP = 14;
	localparam int BERR_OOS      = 15;

	// status codes and alarm handling
	localparam logic [7:0] STATUS_BAD_HW    = 8'h0c;
	localparam logic [7:0] STATUS_BAD_OOS   = 8'h1c;
	localparam logic [7:0] STATUS_ALARM_BIT = 8'h01;
	localparam logic [7:0] ALARM_OFF_LIMIT  = 8'hff;
	localparam logic [15:0] CHANNEL_UNINIT_MAX = 16'h000a;

	// simulate enable codes
	localparam logic [7:0] SIM_DISABLED = 8'h01;
	localparam logic [7:0] SIM_ACTIVE   = 8'h02;

	// tag text
	localparam int         TAG_CHARS  = 32;
	localparam logic [6:0] TAG_SPACE  = 7'h20;

	// filter tick timing
	localparam int CLK_PERIOD_NS = 50;
	localparam int TICK_TIME_NS  = 1000000;
endpackage

//--- design/di_status_block.sv
// discrete input block: field value path, alarm, block error and parameters
`timescale 1ns/10ps
`default_nettype none

module di_status_block
	import di_status_pkg::*;
#(
	parameter int TICK_CYCLES = (TICK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS
) (
	input  wire logic        clk_sys_i,
	input  wire logic        rst_i,
	input  wire logic [7:0]  xd_value_i,
	input  wire logic [7:0]  xd_status_i,
	input  wire logic        xd_oos_i,
	input  wire logic        hw_fail_i,
	input  wire logic        sim_jumper_i,
	input  wire logic        par_wr_i,
	input  wire logic        par_rd_i,
	input  wire logic [7:0]  par_index_i,
	input  wire logic [7:0]  par_sub_i,
	input  wire logic [15:0] par_wdata_i,
	output logic [15:0]      par_rdata_o,
	output logic             par_ack_o,
	output logic             par_err_o,
	output logic [7:0]       field_value_o,
	output logic [7:0]       field_status_o,
	output logic [7:0]       process_value_o,
	output logic [7:0]       process_status_o,
	output logic [7:0]       out_value_o,
	output logic [7:0]       out_status_o,
	output logic             alarm_o,
	output logic [15:0]      block_err_o,
	output logic [7:0]       actual_mode_o,
	output logic             self_test_jumper_o
);

	localparam int TW = $clog2(TICK_CYCLES + 1);

	if (TICK_CYCLES < 2) begin : g_chk
		$error("TICK_CYCLES must be at least 2");
	end

	typedef struct packed {
		logic [TAG_CHARS-1:0][6:0] tag_text;
		logic [15:0] static_revision;
		logic [15:0] grouping_value;
		logic [7:0]  plant_unit_key;
		logic [7:0]  target_mode;
		logic [7:0]  actual_mode;
		logic        io_invert;
		logic [15:0] filter_time;
		logic [7:0]  alarm_state_limit;
		logic [15:0] channel;
		logic        sim_enable;
		logic [7:0]  sim_value;
		logic [7:0]  sim_status;
		logic [7:0]  field_value;
		logic [7:0]  field_status;
		logic [7:0]  process_value;
		logic [7:0]  process_status;
		logic [15:0] filter_count;
		logic [7:0]  out_value;
		logic [7:0]  out_status;
		logic        alarm;
		logic        power_up;
		logic [15:0] block_err;
		logic [TW-1:0] tick_count;
		logic [15:0] rdata;
		logic        ack;
		logic        err;
	} state_t;

	state_t state_ff;
	state_t nxt_state;

	// discrete invert: zero becomes one, anything else becomes zero
	function automatic logic [7:0] invert_discrete(input logic [7:0] v);
		invert_discrete = (v == 8'h00) ? 8'h01 : 8'h00;
	endfunction

	function automatic logic legal_mode(input logic [7:0] m);
		legal_mode = (m == MODE_OOS) || (m == MODE_MAN) || (m == MODE_AUTO);
	endfunction

	always_comb begin
		logic       tick;
		logic       uninit;
		logic       running;
		logic       jumper_ok;
		logic [7:0] src_value;
		logic [7:0] src_status;
		logic [7:0] fval;
		logic [7:0] fst;
		logic [7:0] inv;
		logic [7:0] oval;
		logic [7:0] ost;
		logic       alarm_now;
		logic       static_wr;
		logic [4:0] tag_pos;
		tick       = 1'b0;
		uninit     = 1'b0;
		running    = 1'b0;
		jumper_ok  = 1'b0;
		src_value  = 8'h00;
		src_status = 8'h00;
		fval       = 8'h00;
		fst        = 8'h00;
		inv        = 8'h00;
		oval       = 8'h00;
		ost        = 8'h00;
		alarm_now  = 1'b0;
		static_wr  = 1'b0;
		tag_pos    = 5'h00;
		nxt_state  = state_ff;
		nxt_state.ack = 1'b0;
		nxt_state.err = 1'b0;

		// filter time base
		if (state_ff.tick_count == TW'(TICK_CYCLES - 1)) begin
			nxt_state.tick_count = '0;
			tick = 1'b1;
		end else begin
			nxt_state.tick_count = state_ff.tick_count + TW'(1);
		end

		uninit = (state_ff.channel <= CHANNEL_UNINIT_MAX);
		jumper_ok = sim_jumper_i;

		// actual mode follows a legal target; an unset channel pins it out of service
		if (uninit) begin
			nxt_state.actual_mode = MODE_OOS;
		end else begin
			nxt_state.actual_mode = state_ff.target_mode;
		end
		running = (state_ff.actual_mode != MODE_OOS);
		if (running) begin
			nxt_state.power_up = 1'b0;
		end

		// pulling the jumper ends simulation so it cannot linger unseen
		if (!jumper_ok) begin
			nxt_state.sim_enable = 1'b0;
		end

		// field value source
		if (state_ff.sim_enable) begin
			src_value  = state_ff.sim_value;
			src_status = state_ff.sim_status;
		end else begin
			src_value  = xd_value_i;
			src_status = xd_status_i;
			// simulate fields track live data while disabled
			nxt_state.sim_value  = xd_value_i;
			nxt_state.sim_status = xd_status_i;
		end
		fval = src_value;
		fst  = src_status;
		if (hw_fail_i) begin
			fst = STATUS_BAD_HW;
		end else if (xd_oos_i) begin
			fst = STATUS_BAD_OOS;
		end

		oval = state_ff.out_value;
		ost  = state_ff.out_status;
		if (running) begin
			nxt_state.field_value  = fval;
			nxt_state.field_status = fst;
			inv = state_ff.io_invert ? invert_discrete(fval) : fval;
			// new state must persist for filter_time ticks before it lands
			if (inv == state_ff.process_value) begin
				nxt_state.filter_count = 16'h0000;
			end else if (state_ff.filter_count >= state_ff.filter_time) begin
				nxt_state.process_value = inv;
				nxt_state.filter_count  = 16'h0000;
			end else if (tick) begin
				nxt_state.filter_count = state_ff.filter_count + 16'h0001;
			end
			nxt_state.process_status = fst;
			if (state_ff.actual_mode == MODE_AUTO) begin
				oval = state_ff.process_value;
				ost  = state_ff.process_status;
			end
		end

		// host parameter access; a write in the same cycle overrides the output
		if (par_wr_i) begin
			nxt_state.ack = 1'b1;
			unique case (par_index_i)
				IDX_TAG_TEXT: begin
					tag_pos = par_sub_i[4:0] - 5'h01;
					if (par_sub_i == 8'h00 || par_sub_i > 8'(TAG_CHARS)) begin
						nxt_state.err = 1'b1;
					end else begin
						nxt_state.tag_text[tag_pos] = par_wdata_i[6:0];
						static_wr = 1'b1;
					end
				end
				IDX_GROUPING: begin
					nxt_state.grouping_value = par_wdata_i;
					static_wr = 1'b1;
				end
				IDX_PLANT_KEY: begin
					nxt_state.plant_unit_key = par_wdata_i[7:0];
				end
				IDX_MODE: begin
					if (par_sub_i == SUB_MODE_TARGET && legal_mode(par_wdata_i[7:0])) begin
						nxt_state.target_mode = par_wdata_i[7:0];
					end else begin
						nxt_state.err = 1'b1;
					end
				end
				IDX_OUTPUT: begin
					// manual output only where the mode switch is not driving it
					if (state_ff.actual_mode != MODE_AUTO && par_sub_i == SUB_VALUE) begin
						oval = par_wdata_i[7:0];
					end else if (state_ff.actual_mode != MODE_AUTO &&
						par_sub_i == SUB_STATUS) begin
						ost = par_wdata_i[7:0];
					end else begin
						nxt_state.err = 1'b1;
					end
				end
				IDX_SIMULATE: begin
					if (par_sub_i == SUB_SIM_ENABLE) begin
						if (par_wdata_i[7:0] == SIM_ACTIVE && jumper_ok) begin
							nxt_state.sim_enable = 1'b1;
						end else if (par_wdata_i[7:0] == SIM_DISABLED) begin
							nxt_state.sim_enable = 1'b0;
						end else begin
							nxt_state.err = 1'b1;
						end
					end else if (par_sub_i == SUB_SIM_VALUE && state_ff.sim_enable) begin
						nxt_state.sim_value = par_wdata_i[7:0];
					end else if (par_sub_i == SUB_SIM_STATUS && state_ff.sim_enable) begin
						nxt_state.sim_status = par_wdata_i[7:0];
					end else begin
						nxt_state.err = 1'b1;
					end
				end
				IDX_IO_OPTIONS: begin
					// invert may only change while the block is out of service
					if (state_ff.actual_mode == MODE_OOS) begin
						nxt_state.io_invert = par_wdata_i[0];
						static_wr = 1'b1;
					end else begin
						nxt_state.err = 1'b1;
					end
				end
				IDX_CHANNEL: begin
					nxt_state.channel = par_wdata_i;
					static_wr = 1'b1;
				end
				IDX_FILTER_TIME: begin
					nxt_state.filter_time = par_wdata_i;
					static_wr = 1'b1;
				end
				IDX_ALARM_LIMIT: begin
					nxt_state.alarm_state_limit = par_wdata_i[7:0];
					static_wr = 1'b1;
				end
				default: begin
					nxt_state.err = 1'b1;
				end
			endcase
		end else if (par_rd_i) begin
			nxt_state.ack   = 1'b1;
			nxt_state.rdata = 16'h0000;
			unique case (par_index_i)
				IDX_STATIC_REV:  nxt_state.rdata = state_ff.static_revision;
				IDX_TAG_TEXT: begin
					tag_pos = par_sub_i[4:0] - 5'h01;
					if (par_sub_i == 8'h00 || par_sub_i > 8'(TAG_CHARS)) begin
						nxt_state.err = 1'b1;
					end else begin
						nxt_state.rdata = {9'h000, state_ff.tag_text[tag_pos]};
					end
				end
				IDX_GROUPING:    nxt_state.rdata = state_ff.grouping_value;
				IDX_PLANT_KEY:   nxt_state.rdata = {8'h00, state_ff.plant_unit_key};
				IDX_MODE: begin
					if (par_sub_i == SUB_MODE_ACTUAL) begin
						nxt_state.rdata = {8'h00, state_ff.actual_mode};
					end else begin
						nxt_state.rdata = {8'h00, state_ff.target_mode};
					end
				end
				IDX_BLOCK_ERR:   nxt_state.rdata = state_ff.block_err;
				IDX_PROC_VALUE:  nxt_state.rdata = {state_ff.process_status,
					state_ff.process_value};
				IDX_OUTPUT:      nxt_state.rdata = {state_ff.out_status, state_ff.out_value};
				IDX_FIELD_VALUE: nxt_state.rdata = {state_ff.field_status, state_ff.field_value};
				IDX_SIMULATE: begin
					unique case (par_sub_i)
						SUB_SIM_STATUS: nxt_state.rdata = {8'h00, state_ff.sim_status};
						SUB_SIM_VALUE:  nxt_state.rdata = {8'h00, state_ff.sim_value};
						SUB_XD_STATUS:  nxt_state.rdata = {8'h00, xd_status_i};
						SUB_XD_VALUE:   nxt_state.rdata = {8'h00, xd_value_i};
						SUB_SIM_ENABLE: nxt_state.rdata = state_ff.sim_enable ?
							{8'h00, SIM_ACTIVE} : {8'h00, SIM_DISABLED};
						default:        nxt_state.err = 1'b1;
					endcase
				end
				IDX_IO_OPTIONS:  nxt_state.rdata = {15'h0000, state_ff.io_invert};
				IDX_CHANNEL:     nxt_state.rdata = state_ff.channel;
				IDX_FILTER_TIME: nxt_state.rdata = state_ff.filter_time;
				IDX_ALARM_LIMIT: nxt_state.rdata = {8'h00, state_ff.alarm_state_limit};
				default:         nxt_state.err = 1'b1;
			endcase
		end

		// alarm judged after host writes so a manual output is tested too
		if (running) begin
			alarm_now = (state_ff.alarm_state_limit != ALARM_OFF_LIMIT) &&
				(oval == state_ff.alarm_state_limit);
			nxt_state.alarm = alarm_now;
		end
		// substatus bit always mirrors the alarm, whatever the host wrote
		ost = (ost & ~STATUS_ALARM_BIT) | (nxt_state.alarm ? STATUS_ALARM_BIT : 8'h00);
		nxt_state.out_value  = oval;
		nxt_state.out_status = ost;
		if (static_wr) begin
			nxt_state.static_revision = state_ff.static_revision + 16'h0001;
		end

		nxt_state.block_err = 16'h0000;
		nxt_state.block_err[BERR_CONFIG]   = uninit;
		nxt_state.block_err[BERR_SIMULATE] = nxt_state.sim_enable;
		nxt_state.block_err[BERR_BAD_PV]   = hw_fail_i | xd_oos_i;
		nxt_state.block_err[BERR_POWER_UP] = nxt_state.power_up;
		nxt_state.block_err[BERR_OOS]      = (nxt_state.actual_mode == MODE_OOS);
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			state_ff <= '0;
			state_ff.tag_text <= {TAG_CHARS{TAG_SPACE}};
			state_ff.target_mode <= MODE_OOS;
			state_ff.actual_mode <= MODE_OOS;
			state_ff.alarm_state_limit <= ALARM_OFF_LIMIT;
			state_ff.power_up <= 1'b1;
			state_ff.block_err <= 16'((1 << BERR_CONFIG) | (1 << BERR_POWER_UP) | (1 << BERR_OOS));
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign par_rdata_o        = state_ff.rdata;
	assign par_ack_o          = state_ff.ack;
	assign par_err_o          = state_ff.err;
	assign field_value_o      = state_ff.field_value;
	assign field_status_o     = state_ff.field_status;
	assign process_value_o    = state_ff.process_value;
	assign process_status_o   = state_ff.process_status;
	assign out_value_o        = state_ff.out_value;
	assign out_status_o       = state_ff.out_status;
	assign alarm_o            = state_ff.alarm;
	assign block_err_o        = state_ff.block_err;
	assign actual_mode_o      = state_ff.actual_mode;
	assign self_test_jumper_o = sim_jumper_i;

endmodule

`default_nettype wire

//--- verification/di_status_checker.sv
// port-level assertions for the discrete input status block
`timescale 1ns/10ps
`default_nettype none
module di_status_checker
	import di_status_pkg::*;
(
	input wire logic        clk_sys_i,
	input wire logic        rst_i,
	input wire logic        hw_fail_i,
	input wire logic        xd_oos_i,
	input wire logic        sim_jumper_i,
	input wire logic        par_wr_i,
	input wire logic        par_rd_i,
	input wire logic        par_ack_o,
	input wire logic [7:0]  field_status_o,
	input wire logic [7:0]  process_value_o,
	input wire logic [7:0]  out_value_o,
	input wire logic [7:0]  out_status_o,
	input wire logic        alarm_o,
	input wire logic [15:0] block_err_o,
	input wire logic [7:0]  actual_mode_o,
	input wire logic        self_test_jumper_o
);
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);
	wire logic out_of_service = actual_mode_o == MODE_OOS;

	AST_ACK: assert property (1 |=> par_ack_o == $past(par_wr_i || par_rd_i))
		else $error("answer not one cycle after request");
	AST_ALARM_FLAG: assert property (alarm_o |-> out_status_o[0])
		else $error("alarm without output substatus");
	AST_BAD_PV: assert property (1 |=> block_err_o[BERR_BAD_PV] == $past(hw_fail_i || xd_oos_i))
		else $error("bad input bit wrong");
	AST_POWER_UP: assert property (!block_err_o[BERR_POWER_UP] |=> !block_err_o[BERR_POWER_UP])
		else $error("power-up bit came back");
	AST_OOS_BIT: assert property (out_of_service && $past(out_of_service) |-> block_err_o[BERR_OOS])
		else $error("out of service bit missing");
	// the host may still write the output while out of service
	AST_OOS_HOLD: assert property (out_of_service && $past(out_of_service) && !$past(par_wr_i) |->
		$stable(process_value_o) && $stable(out_value_o))
		else $error("values moved while out of service");
	AST_HW_STATUS: assert property (hw_fail_i && !out_of_service |=> field_status_o == STATUS_BAD_HW)
		else $error("hardware failure status wrong");
	AST_XD_STATUS: assert property (xd_oos_i && !hw_fail_i && !out_of_service |=> field_status_o == STATUS_BAD_OOS)
		else $error("transducer out status wrong");
	AST_JUMPER_FLAG: assert property (self_test_jumper_o == sim_jumper_i)
		else $error("jumper flag differs from jumper");
	// allow two cycles; the enable and its error bit both drop one cycle after the jumper
	AST_SIM_JUMPER: assert property ((!sim_jumper_i) [*3] |-> !block_err_o[BERR_SIMULATE])
		else $error("simulation active without jumper");
	AST_AUTO_OUT: assert property (actual_mode_o == MODE_AUTO |=> out_value_o == $past(process_value_o))
		else $error("output not following process value");
endmodule
`default_nettype wire

//--- verification/xd_model.sv
// transducer block stand-in feeding discrete value and status
`timescale 1ns/10ps
`default_nettype none
module xd_model (
	input  wire logic       clk_sys_i,
	input  wire logic       rst_i,
	input  wire logic [7:0] val_i,
	input  wire logic [7:0] sts_i,
	output logic [7:0]      xd_value_o,
	output logic [7:0]      xd_status_o
);
	// one cycle of lag, as a transducer update would have
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			xd_value_o <= 8'h00;
			xd_status_o <= 8'h00;
		end else begin
			xd_value_o <= val_i;
			xd_status_o <= sts_i;
		end
	end
endmodule
`default_nettype wire

//--- verification/tb.sv
// self-checking bench for the discrete input status block
`timescale 1ns/10ps
`default_nettype none
module tb;
	import di_status_pkg::*;
	logic        clk_sys_i = 0, rst_i = 1, xd_oos_i = 0, hw_fail_i = 0, sim_jumper_i = 0;
	logic        par_wr_i = 0, par_rd_i = 0, par_ack_o, par_err_o, alarm_o, self_test_jumper_o;
	logic [7:0]  par_index_i = 0, par_sub_i = 0, val = 0, sts = 0, xd_value_i, xd_status_i;
	logic [7:0]  field_value_o, field_status_o, process_value_o, process_status_o;
	logic [7:0]  out_value_o, out_status_o, actual_mode_o, m_lim = 8'hff;
	logic [15:0] par_wdata_i = 0, par_rdata_o, block_err_o;
	logic [31:0] r;
	logic        m_inv = 0;
	int          error_cnt = 0, comparisons = 0, cyc = 0, m_rev = 0;

	di_status_block #(.TICK_CYCLES(4)) dut (.*);
	xd_model xd (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .val_i(val), .sts_i(sts),
		.xd_value_o(xd_value_i), .xd_status_o(xd_status_i));

	always #25 clk_sys_i = ~clk_sys_i;
	always @(posedge clk_sys_i) begin
		cyc++;
		if (cyc == 4000) begin
			error_cnt++;
			summarize();
		end
	end

	task automatic summarize();
		$display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(string n, logic [15:0] e, logic [15:0] g);
		comparisons++;
		if (g !== e) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic tick(int n);
		repeat (n) @(negedge clk_sys_i);
	endtask
	// answer is fixed at one cycle, so no polling is needed
	task automatic acc(logic w, logic [7:0] i, logic [7:0] b, logic [15:0] d, logic e);
		@(posedge clk_sys_i);
		par_wr_i <= w;
		par_rd_i <= !w;
		par_index_i <= i;
		par_sub_i <= b;
		par_wdata_i <= d;
		@(posedge clk_sys_i);
		par_wr_i <= 0;
		par_rd_i <= 0;
		@(negedge clk_sys_i);
		chk("ack", 1, par_ack_o);
		chk("err", e, par_err_o);
		if (w && !e && i inside {2, 3, 13, 15, 16, 23})
			m_rev++;
	endtask
	task automatic rdc(string n, logic [7:0] i, logic [7:0] b, logic [15:0] e);
		acc(0, i, b, 16'h0000, 0);
		chk(n, e, par_rdata_o);
	endtask
	task automatic path(logic [7:0] x);
		logic [7:0] p;
		// logical invert: zero reads as one, anything else as zero
		p = m_inv ? 8'(x == 8'h00) : x;
		@(posedge clk_sys_i);
		val <= x;
		tick(8);
		chk("field", x, field_value_o);
		chk("fstat", sts, field_status_o);
		chk("pv", p, process_value_o);
		chk("out", p, out_value_o);
		chk("alarm", m_lim != 8'hff && p == m_lim, alarm_o);
	endtask

	initial begin
		r = $urandom(17);
		repeat (5) @(posedge clk_sys_i);
		rst_i <= 0;
		tick(1);
		chk("mode", MODE_OOS, actual_mode_o);
		chk("berr", 16'hc002, block_err_o);
		rdc("rev", IDX_STATIC_REV, 8'h00, 16'h0000);
		rdc("grp", IDX_GROUPING, 8'h00, 16'h0000);
		rdc("key", IDX_PLANT_KEY, 8'h00, 16'h0000);
		rdc("tag", IDX_TAG_TEXT, 8'h01, TAG_SPACE);
		r = $urandom;
		@(posedge clk_sys_i);
		sts <= r[31:24];
		acc(1, IDX_GROUPING, 8'h00, r[15:0], 0);
		acc(1, IDX_PLANT_KEY, 8'h00, r[23:16], 0);
		rdc("grp", IDX_GROUPING, 8'h00, r[15:0]);
		rdc("key", IDX_PLANT_KEY, 8'h00, r[23:16]);
		acc(1, IDX_TAG_TEXT, 8'h21, 16'h0041, 1);
		acc(1, IDX_TAG_TEXT, 8'h20, 16'h00c1, 0);
		rdc("tag", IDX_TAG_TEXT, 8'h20, 16'h0041);
		acc(1, 8'h0e, 8'h00, 16'h0000, 1);
		acc(1, IDX_CHANNEL, 8'h00, CHANNEL_UNINIT_MAX, 0);
		acc(1, IDX_MODE, SUB_MODE_TARGET, MODE_AUTO, 0);
		tick(3);
		chk("mode", MODE_OOS, actual_mode_o);
		acc(1, IDX_CHANNEL, 8'h00, CHANNEL_UNINIT_MAX + 16'h0001, 0);
		tick(3);
		chk("mode", MODE_AUTO, actual_mode_o);
		chk("berr", 16'h0000, block_err_o);
		rdc("rev", IDX_STATIC_REV, 8'h00, m_rev[15:0]);
		repeat (4) path(8'($urandom));
		m_lim = r[7:0];
		acc(1, IDX_ALARM_LIMIT, 8'h00, m_lim, 0);
		path(m_lim);
		path(~m_lim);
		m_lim = 8'hff;
		acc(1, IDX_ALARM_LIMIT, 8'h00, m_lim, 0);
		path(8'hff);
		@(posedge clk_sys_i);
		hw_fail_i <= 1;
		xd_oos_i <= 1;
		tick(4);
		chk("fstat", STATUS_BAD_HW, field_status_o);
		chk("pstat", STATUS_BAD_HW, process_status_o);
		chk("bad", 1, block_err_o[BERR_BAD_PV]);
		@(posedge clk_sys_i);
		hw_fail_i <= 0;
		tick(4);
		chk("pstat", STATUS_BAD_OOS, process_status_o);
		chk("ostat", STATUS_BAD_OOS, out_status_o);
		@(posedge clk_sys_i);
		xd_oos_i <= 0;
		acc(1, IDX_SIMULATE, SUB_SIM_VALUE, 16'h005a, 1);
		acc(1, IDX_SIMULATE, SUB_SIM_ENABLE, SIM_ACTIVE, 1);
		@(posedge clk_sys_i);
		sim_jumper_i <= 1;
		tick(1);
		chk("jump", 1, self_test_jumper_o);
		acc(1, IDX_SIMULATE, SUB_SIM_ENABLE, SIM_ACTIVE, 0);
		acc(1, IDX_SIMULATE, SUB_SIM_VALUE, 16'h005a, 0);
		acc(1, IDX_SIMULATE, SUB_SIM_STATUS, 16'h0080, 0);
		tick(4);
		chk("field", 8'h5a, field_value_o);
		chk("fstat", 8'h80, field_status_o);
		chk("sim", 1, block_err_o[BERR_SIMULATE]);
		rdc("xdv", IDX_SIMULATE, SUB_XD_VALUE, val);
		rdc("xds", IDX_SIMULATE, SUB_XD_STATUS, sts);
		@(posedge clk_sys_i);
		sim_jumper_i <= 0;
		tick(4);
		chk("sim", 0, block_err_o[BERR_SIMULATE]);
		acc(1, IDX_IO_OPTIONS, 8'h00, 16'h0001, 1);
		acc(1, IDX_MODE, SUB_MODE_TARGET, MODE_OOS, 0);
		acc(1, IDX_IO_OPTIONS, 8'h00, 16'h0001, 0);
		acc(1, IDX_MODE, SUB_MODE_TARGET, MODE_AUTO, 0);
		m_inv = 1;
		path(8'($urandom));
		// manual mode: host owns the output and the alarm still watches it
		acc(1, IDX_MODE, SUB_MODE_TARGET, MODE_MAN, 0);
		m_lim = 8'h33;
		acc(1, IDX_ALARM_LIMIT, 8'h00, m_lim, 0);
		acc(1, IDX_OUTPUT, SUB_VALUE, m_lim, 0);
		chk("out", m_lim, out_value_o);
		chk("alarm", 1, alarm_o);
		chk("aflag", STATUS_ALARM_BIT, out_status_o & STATUS_ALARM_BIT);
		acc(1, IDX_MODE, SUB_MODE_TARGET, MODE_AUTO, 0);
		acc(1, IDX_OUTPUT, SUB_VALUE, m_lim, 1);
		rdc("rev", IDX_STATIC_REV, 8'h00, m_rev[15:0]);
		summarize();
	end
endmodule

bind di_status_block di_status_checker chk_i (.*);
`default_nettype wire
